// ---- hw/fixed_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "node_defs.svh"

module fixed_arbiter (
  input wire logic [`NODE_PORTS-1:0] bid_i,
  input wire logic [`NODE_PORTS-1:0][`PORT_IDX_W-1:0] bid_port_i,
  input wire logic [`NODE_PORTS-1:0] port_free_i,
  output logic [`NODE_PORTS-1:0] grant_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Lower input index wins a contest for the same port
  for (genvar gi = 0; gi < `NODE_PORTS; gi++)
  begin : g_bid
    logic blocked;
    always_comb
    begin
      blocked = 1'b0;
      for (int j = 0; j < gi; j++)
      begin
        if (bid_i[j] && (bid_port_i[j] == bid_port_i[gi]))
          blocked = 1'b1;
      end
      grant_o[gi] = bid_i[gi] && port_free_i[bid_port_i[gi]] && !blocked;
    end
  end

endmodule
`default_nettype wire

// ---- hw/flow_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "node_defs.svh"

module flow_fifo #(
  parameter int WIDTH = `FLIT_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = `FIFO_AW
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Status from pointers with one wrap bit
  assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer update, flush empties the buffer
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush_i)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end
    else
    begin
      if (push)
        next_wr_ptr = wr_ptr + 1'b1;
      if (pop)
        next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage write
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;
  end

endmodule
`default_nettype wire

// ---- hw/node_defs.svh ----
`ifndef NODE_DEFS_SVH
`define NODE_DEFS_SVH

// Number of input and output ports of a base-four node
`define NODE_PORTS 4
// Width of a port index and of a routing digit
`define PORT_IDX_W 2
// Width of one data digit on a channel
`define DIGIT_W 4
// Lowest data line that carries the routing digit
`define ROUTE_LSB 0
// Buffered word: frame bit above the data digit
`define FLIT_W 5
`define FLIT_FRAME_BIT 4
// Output buffer depth and its address width; pointers are one bit wider
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// ---- hw/node_pkg.sv ----
package node_pkg;

  // Per-input channel state
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_LINK = 2'h1,
    ST_RETREAT = 2'h2
  } link_state_t;

  // Index of a node port
  typedef logic [1:0] port_idx_t;

endpackage

// ---- hw/switch_node.sv ----
// Overview of operation
// - Channel: four data, frame, retreat, two flow
// - Link formed at head, dropped at tail
// - Routing digit from data lines zero, one
// - Free port, no better bid; code latched
// - Frame forwarded one clock late, digit dropped
// - Retreat sent when port busy or lost
// - Retreat clears frame, moves one node/clock
// - Node passes data without any error checking
`timescale 1ns/1ps
`default_nettype none
`include "node_defs.svh"

module switch_node (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [`NODE_PORTS-1:0][`DIGIT_W-1:0] in_data_i,
  input wire logic [`NODE_PORTS-1:0] in_frame_i,
  output logic [`NODE_PORTS-1:0] in_reject_o,
  input wire logic [`NODE_PORTS-1:0] in_block_flow_line_a_i,
  output logic [`NODE_PORTS-1:0] in_hold_o,
  output logic [`NODE_PORTS-1:0][`DIGIT_W-1:0] out_data_o,
  output logic [`NODE_PORTS-1:0] out_frame_o,
  input wire logic [`NODE_PORTS-1:0] out_reject_i,
  output logic [`NODE_PORTS-1:0] out_block_flow_line_a_o,
  input wire logic [`NODE_PORTS-1:0] out_hold_i
);

  node_pkg::link_state_t state [`NODE_PORTS];
  node_pkg::link_state_t next_state [`NODE_PORTS];
  node_pkg::port_idx_t route [`NODE_PORTS];
  node_pkg::port_idx_t next_route [`NODE_PORTS];
  logic [`NODE_PORTS-1:0] frame_q;
  logic [`NODE_PORTS-1:0] next_frame_q;
  logic [`NODE_PORTS-1:0] head;
  logic [`NODE_PORTS-1:0] grant;
  logic [`NODE_PORTS-1:0][`PORT_IDX_W-1:0] bid_port;
  logic [`NODE_PORTS-1:0] port_free;
  logic [`NODE_PORTS-1:0] out_busy;
  logic [`NODE_PORTS-1:0] push;
  logic [`NODE_PORTS-1:0] fifo_in_ready;
  logic [`NODE_PORTS-1:0] fifo_out_valid;
  logic [`NODE_PORTS-1:0][`FLIT_W-1:0] push_word;
  logic [`NODE_PORTS-1:0][`FLIT_W-1:0] head_word;
  logic [`NODE_PORTS-1:0] flow_a;
  logic [`NODE_PORTS-1:0] next_flow_a;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Bid arbitration across all inputs
  fixed_arbiter u_arbiter (
    .bid_i(head),
    .bid_port_i(bid_port),
    .port_free_i(port_free),
    .grant_o(grant)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input channel logic, one copy per input port
  for (genvar gi = 0; gi < `NODE_PORTS; gi++)
  begin : g_in
    // Head is a rising frame on an idle channel; it carries the bid
    assign head[gi] = (state[gi] == node_pkg::ST_IDLE) && in_frame_i[gi] && !frame_q[gi];
    assign bid_port[gi] = in_data_i[gi][`ROUTE_LSB +: `PORT_IDX_W];

    // Retreat toward the source comes straight from the state flops
    assign in_reject_o[gi] = (state[gi] == node_pkg::ST_RETREAT);

    // Ask the source to pause while the linked output buffer is full
    assign in_hold_o[gi] = (state[gi] == node_pkg::ST_LINK) && !fifo_in_ready[route[gi]];

    // Channel state transitions
    always_comb
    begin
      next_state[gi] = state[gi];
      next_route[gi] = route[gi];
      next_frame_q[gi] = in_frame_i[gi];
      unique case (state[gi])
        node_pkg::ST_IDLE:
        begin
          if (head[gi] && grant[gi])
          begin
            next_state[gi] = node_pkg::ST_LINK;
            next_route[gi] = bid_port[gi];
          end
          else if (head[gi])
          begin
            next_state[gi] = node_pkg::ST_RETREAT;
            next_frame_q[gi] = 1'b0;
          end
        end
        node_pkg::ST_LINK:
        begin
          if (out_reject_i[route[gi]])
          begin
            next_state[gi] = node_pkg::ST_RETREAT;
            next_frame_q[gi] = 1'b0;
          end
          else if (!frame_q[gi])
            next_state[gi] = node_pkg::ST_IDLE;
        end
        node_pkg::ST_RETREAT:
        begin
          // Frame flops stay clear until the source drops its frame
          next_frame_q[gi] = 1'b0;
          if (!in_frame_i[gi])
            next_state[gi] = node_pkg::ST_IDLE;
        end
        default:
        begin
          next_state[gi] = node_pkg::ST_IDLE;
          next_frame_q[gi] = 1'b0;
        end
      endcase
    end

    // Channel registers
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
      begin
        state[gi] <= node_pkg::ST_IDLE;
        route[gi] <= 2'h0;
        frame_q[gi] <= 1'b0;
      end
      else
      begin
        state[gi] <= next_state[gi];
        route[gi] <= next_route[gi];
        frame_q[gi] <= next_frame_q[gi];
      end
    end

    // Granted head forms the link with the digit's port
    a_link_on_grant: assert property (head[gi] && grant[gi] |=>
      state[gi] == node_pkg::ST_LINK && route[gi] == $past(bid_port[gi]))
      else $error("granted head did not form link");

    // Losing or blocked bid retreats next clock
    a_reject_on_lose: assert property (head[gi] && !grant[gi] |=> in_reject_o[gi])
      else $error("lost bid did not retreat");

    // Busy port always refuses a new head
    a_busy_port_reject: assert property (head[gi] && out_busy[bid_port[gi]]
      |=> in_reject_o[gi])
      else $error("head to busy port not refused");

    // Downstream retreat passes one node upstream per clock
    a_retreat_step: assert property ((state[gi] == node_pkg::ST_LINK)
      && out_reject_i[route[gi]] |=> in_reject_o[gi] && !frame_q[gi])
      else $error("retreat not passed upstream in one clock");

    // Connection code held for the whole message
    a_route_held: assert property ((state[gi] == node_pkg::ST_LINK)
      && $past(state[gi] == node_pkg::ST_LINK) |-> route[gi] == $past(route[gi]))
      else $error("connection code changed mid message");

    // Tail leaving releases the link
    a_tail_release: assert property ((state[gi] == node_pkg::ST_LINK) && !frame_q[gi]
      && !out_reject_i[route[gi]] |=> state[gi] == node_pkg::ST_IDLE)
      else $error("link not released at tail");

    // Frame reaches the output buffer one clock after the data digit
    a_frame_delayed: assert property ((state[gi] == node_pkg::ST_LINK)
      && frame_q[gi] && in_frame_i[gi] && !out_reject_i[route[gi]] |=> push[route[gi]])
      else $error("delayed frame not forwarded");

    // Retreat holds while the source keeps its frame up
    a_retreat_holds: assert property (in_reject_o[gi] && in_frame_i[gi]
      |=> in_reject_o[gi] && !frame_q[gi])
      else $error("retreat dropped before frame");

    // Flow line of a linked input reaches its output one clock later
    a_flow_copied: assert property ((state[gi] == node_pkg::ST_LINK)
      |=> out_block_flow_line_a_o[$past(route[gi])] == $past(in_block_flow_line_a_i[gi]))
      else $error("flow line not forwarded");

    // The routing digit of a granted head is never buffered
    a_head_dropped: assert property (head[gi] && grant[gi] |-> !push[bid_port[gi]])
      else $error("routing digit forwarded");

    // A port still draining an earlier message refuses a new head
    a_no_merge: assert property (head[gi] && fifo_out_valid[bid_port[gi]]
      |=> in_reject_o[gi])
      else $error("head merged into draining port");

    // Input 0 beats any other input bidding for the same port
    if (gi > 0)
    begin : g_prio
      a_priority_fixed: assert property (head[gi] && head[0]
        && bid_port[0] == bid_port[gi] |=> in_reject_o[gi])
        else $error("fixed priority not kept");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output port logic, one copy per output port
  for (genvar go = 0; go < `NODE_PORTS; go++)
  begin : g_out
    logic [`NODE_PORTS-1:0] owner;

    // Find the linked input and pick its delayed-frame digit
    always_comb
    begin
      owner = '0;
      out_busy[go] = 1'b0;
      push[go] = 1'b0;
      push_word[go] = '0;
      next_flow_a[go] = 1'b0;
      for (int j = 0; j < `NODE_PORTS; j++)
      begin
        if ((state[j] == node_pkg::ST_LINK) && (route[j] == node_pkg::port_idx_t'(go)))
        begin
          owner[j] = 1'b1;
          out_busy[go] = 1'b1;
          next_flow_a[go] = in_block_flow_line_a_i[j];
          // Frame delayed one clock drops the routing digit
          push[go] = frame_q[j];
          // Digits pass through untouched, no checking here
          push_word[go] = {frame_q[j], in_data_i[j]};
        end
      end
    end

    // Port free only when unlinked and fully drained
    assign port_free[go] = !out_busy[go] && !fifo_out_valid[go];

    // Output buffer; a downstream retreat discards what is queued
    flow_fifo #(
      .WIDTH(`FLIT_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
    ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .flush_i(out_reject_i[go]),
      .in_valid_i(push[go]),
      .in_ready_o(fifo_in_ready[go]),
      .in_data_i(push_word[go]),
      .out_valid_o(fifo_out_valid[go]),
      .out_ready_i(!out_hold_i[go]),
      .out_data_o(head_word[go])
    );

    // Downstream channel lines
    assign out_frame_o[go] = fifo_out_valid[go] && head_word[go][`FLIT_FRAME_BIT];
    assign out_data_o[go] = head_word[go][`DIGIT_W-1:0];
    assign out_block_flow_line_a_o[go] = flow_a[go];

    // Flow line register
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
        flow_a[go] <= 1'b0;
      else
        flow_a[go] <= next_flow_a[go];
    end

    // Never more than one input linked to a port
    a_single_owner: assert property ($onehot0(owner))
      else $error("two inputs linked to one port");

    // Retreat from downstream empties this port's buffer
    a_retreat_flush: assert property (out_reject_i[go] |=> !fifo_out_valid[go]
      || push[go] && $past(push[go]))
      else $error("buffer kept data after retreat");

    // A stalled output keeps its word and frame
    a_hold_freezes: assert property (out_hold_i[go] && out_frame_o[go]
      && !out_reject_i[go] |=> out_frame_o[go] && $stable(out_data_o[go]))
      else $error("stalled output moved");

    c_buffer_full: cover property (out_busy[go] && !fifo_in_ready[go]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios
  c_link_made: cover property (head[1] && grant[1] ##[1:20] !out_busy[0] && !out_busy[1]);
  c_contest: cover property (head[0] && head[2] && bid_port[0] == bid_port[2]);
  c_retreat_mid: cover property ((state[3] == node_pkg::ST_LINK) && out_reject_i[route[3]]);
  c_busy_bid: cover property (head[2] && out_busy[bid_port[2]]);

endmodule
`default_nettype wire

// ---- tb/node_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "node_defs.svh"

module node_partner #(
  parameter logic [`DIGIT_W-1:0] REPLY_TYPE = 4'hF
)
(
  input wire logic clk_sys_i,
  input wire logic clear_i,
  input wire logic [`NODE_PORTS-1:0] stall_i,
  input wire logic [`NODE_PORTS-1:0] abort_i,
  input wire logic [`NODE_PORTS-1:0][`DIGIT_W-1:0] data_i,
  input wire logic [`NODE_PORTS-1:0] frame_i,
  output logic [`NODE_PORTS-1:0] reject_o,
  output logic [`NODE_PORTS-1:0] hold_o
);
  logic [`DIGIT_W-1:0] rx [`NODE_PORTS][32];
  logic [5:0] rx_n [`NODE_PORTS];
  logic [`NODE_PORTS-1:0] take_reply;

  //////////////////////////////////////////////////////////////////////////////
  // A reply is taken even while stalled, judged by its type digit
  for (genvar gp = 0; gp < `NODE_PORTS; gp++)
  begin : g_reply
    assign take_reply[gp] = (rx_n[gp] == 6'h00) ? (data_i[gp] == REPLY_TYPE)
      : (rx[gp][0] == REPLY_TYPE);
  end

  // Abort goes straight onto the upstream reject line; stall drives hold except while a reply frame is seen
  assign hold_o = stall_i & ~(frame_i & take_reply);
  assign reject_o = abort_i;

  // Log up to 32 words taken while the frame is high and hold is low
  always_ff @(posedge clk_sys_i)
  begin
    for (int p = 0; p < `NODE_PORTS; p++)
    begin
      if (clear_i)
        rx_n[p] <= 6'h00;
      else if (frame_i[p] && !hold_o[p] && rx_n[p] < 6'h20)
      begin
        rx[p][rx_n[p][4:0]] <= data_i[p];
        rx_n[p] <= rx_n[p] + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_retreat_switch_node_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "node_defs.svh"
`define CHECK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("unexpected %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module test_retreat_switch_node_channel;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic clear = 1'b1;
  logic [3:0][3:0] in_data = '0;
  logic [3:0] in_frame = 4'h0;
  logic [3:0] in_flow = 4'h0;
  logic [3:0] stall = 4'h0;
  logic [3:0] abort = 4'h0;
  logic [3:0] in_reject, in_hold, out_frame, out_flow, out_reject, out_hold;
  logic [3:0][3:0] out_data;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Clock, block and far-side model
  always #2.5 clk_sys_i = ~clk_sys_i;

  switch_node uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .in_data_i(in_data),
    .in_frame_i(in_frame), .in_reject_o(in_reject), .in_block_flow_line_a_i(in_flow),
    .in_hold_o(in_hold), .out_data_o(out_data), .out_frame_o(out_frame),
    .out_reject_i(out_reject), .out_block_flow_line_a_o(out_flow), .out_hold_i(out_hold));

  node_partner partner (.clk_sys_i(clk_sys_i), .clear_i(clear), .stall_i(stall),
    .abort_i(abort), .data_i(out_data), .frame_i(out_frame), .reject_o(out_reject),
    .hold_o(out_hold));

  // Cut a hung run short
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Source: head digit, n body digits obeying hold, trailing digit; quits on retreat
  task automatic src(input int i, input logic [3:0] head, input int n,
    input logic [3:0] base, output logic rej);
    int k;
    k = 0;
    rej = 1'b0;
    // Body never longer than one block of 256 bytes, two digits a byte
    `CHECK("block size", 1'b1, n <= 512)
    @(negedge clk_sys_i);
    in_frame[i] = 1'b1;
    in_data[i] = head;
    while (k < n && !rej)
    begin
      @(negedge clk_sys_i);
      if (in_reject[i] === 1'b1)
        rej = 1'b1;
      else if (in_hold[i] === 1'b0)
      begin
        in_data[i] = 4'(base + k + 1);
        k++;
      end
    end
    if (rej)
      in_frame[i] = 1'b0;
    else
    begin
      @(negedge clk_sys_i);
      while (in_hold[i] === 1'b1)
        @(negedge clk_sys_i);
      in_frame[i] = 1'b0;
      in_data[i] = 4'(base + n + 1);
      @(negedge clk_sys_i);
      in_data[i] = ~in_data[i];
    end
  endtask

  // Wait for all output traffic and retreats to end, then one more clock
  task automatic fresh;
    int w;
    w = 0;
    while ((out_frame !== 4'h0 || in_reject !== 4'h0) && w < 200)
    begin
      @(negedge clk_sys_i);
      w++;
    end
    if (w == 200)
      miscompares++;
    @(negedge clk_sys_i);
  endtask

  task automatic expect_stream(input int p, input int n, input logic [3:0] base);
    `CHECK("word count", 6'(n + 1), partner.rx_n[p])
    for (int k = 0; k <= n; k++)
      `CHECK("word", 4'(base + k + 1), partner.rx[p][k])
  endtask

  task automatic start;
    fresh();
    clear = 1'b1;
    @(negedge clk_sys_i);
    clear = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Plain route with high data lines set in the head; flow line follows
  task automatic route_basic;
    logic r;
    start();
    fork
      src(0, 4'hE, 5, 4'hA, r);
      begin
        repeat (3) @(negedge clk_sys_i);
        in_flow[0] = 1'b1;
        @(negedge clk_sys_i);
        `CHECK("flow out", 4'h4, out_flow)
        in_flow[0] = 1'b0;
      end
    join
    `CHECK("no retreat", 1'b0, r)
    fresh();
    expect_stream(2, 5, 4'hA);
  endtask

  // Two heads for one port in one cycle: lower index wins
  task automatic contest;
    logic r1, r3;
    start();
    fork
      src(1, 4'h5, 4, 4'h3, r1);
      begin
        src(3, 4'h1, 4, 4'h8, r3);
        `CHECK("retreat stands", 1'b1, in_reject[3])
        repeat (2) @(negedge clk_sys_i);
        `CHECK("retreat ends", 1'b0, in_reject[3])
      end
    join
    `CHECK("winner", 1'b0, r1)
    `CHECK("loser", 1'b1, r3)
    fresh();
    expect_stream(1, 4, 4'h3);
  endtask

  // Head for a port already carrying a message
  task automatic busy_port;
    logic r0, r2;
    start();
    fork
      src(0, 4'h3, 6, 4'h1, r0);
      begin
        repeat (3) @(negedge clk_sys_i);
        src(2, 4'h3, 2, 4'h9, r2);
      end
    join
    `CHECK("busy retreat", 1'b1, r2)
    fresh();
    expect_stream(3, 6, 4'h1);
  endtask

  // Far side aborts in mid-message: retreat one clock later, output flushed
  task automatic far_abort;
    logic r;
    start();
    fork
      src(2, 4'h0, 8, 4'h5, r);
      begin
        repeat (4) @(negedge clk_sys_i);
        `CHECK("before abort", 1'b0, in_reject[2])
        abort[0] = 1'b1;
        @(negedge clk_sys_i);
        abort[0] = 1'b0;
        `CHECK("retreat passed up", 1'b1, in_reject[2])
        `CHECK("output flushed", 1'b0, out_frame[0])
      end
    join
    `CHECK("source retreated", 1'b1, r)
  endtask

  // Stalled far side fills the buffer until hold, then everything drains
  task automatic backpressure;
    logic r;
    int w;
    start();
    stall[1] = 1'b1;
    fork
      src(3, 4'h1, 20, 4'h0, r);
      begin
        w = 0;
        while (in_hold[3] !== 1'b1 && w < 40)
        begin
          @(negedge clk_sys_i);
          w++;
        end
        `CHECK("fill depth", 18, w)
        `CHECK("frame held", 1'b1, out_frame[1])
        `CHECK("nothing taken", 6'h00, partner.rx_n[1])
        repeat (4) @(negedge clk_sys_i);
        stall[1] = 1'b0;
      end
    join
    fresh();
    expect_stream(1, 20, 4'h0);
  endtask

  // Refused request: the queued reply goes first, then the request takes another path
  task automatic detour_retry;
    logic r0, rq, rp;
    int t_req;
    int t_rep;
    int w;
    start();
    stall[1] = 1'b1;
    fork
      src(0, 4'h3, 12, 4'h0, r0);
      begin
        repeat (2) @(negedge clk_sys_i);
        t_req = cycles;
        src(2, 4'h7, 3, 4'h2, rq);
        `CHECK("request refused", 1'b1, rq)
        // Reply buffer is looked at before the retry and its reply sent first
        t_rep = cycles;
        src(2, 4'h1, 2, 4'hE, rp);
        `CHECK("reply timer", 1'b1, cycles - t_rep < 20)
        w = 0;
        while (partner.rx_n[1] !== 6'h03 && w < 20)
        begin
          @(negedge clk_sys_i);
          w++;
        end
        `CHECK("reply taken while stalled", 6'h03, partner.rx_n[1])
        `CHECK("reply wait", 1'b1, cycles - t_req < 30)
        // Fixed back-off per source stands in for the randomised one
        repeat (4) @(negedge clk_sys_i);
        // Routing bit 0 flipped: port 3 refused the request, port 2 is the other path
        src(2, 4'h6, 3, 4'h2, rq);
        `CHECK("retry delivered", 1'b0, rq)
        `CHECK("request timer", 1'b1, cycles - t_req < 60)
      end
    join
    `CHECK("long message", 1'b0, r0)
    `CHECK("reply accepted", 1'b0, rp)
    stall[1] = 1'b0;
    fresh();
    expect_stream(1, 2, 4'hE);
    expect_stream(2, 3, 4'h2);
    expect_stream(3, 12, 4'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    `CHECK("reset retreat", 4'h0, in_reject)
    `CHECK("reset frame", 4'h0, out_frame)
    `CHECK("reset hold", 4'h0, in_hold)
    `CHECK("reset flow", 4'h0, out_flow)
    route_basic();
    contest();
    busy_port();
    far_abort();
    backpressure();
    detour_retry();
    conclude();
  end
endmodule
`default_nettype wire
